// ===== rtl/uvrd_decoder.sv
// uvrd_decoder: vendor control request decoder, top level
// assumes the device core gives a one-cycle setup strobe on core_clk_in,
// handles the status stage, and turns stall_out into a protocol stall
//
// What this block does
// - commands only via vendor requests on endpoint 0
// - quick: type 0x40, all fields zero
// - 7-bit write: value in wValue, upper bits zero
// - 32-bit write: wIndex high, wValue low half
// - block read: type 0xC0, wValue zero
// - block read starts at wIndex offset
// - read returns wLength bytes, 1 to 128
// - response bytes go least-significant first
// - set setting: 8-bit value, wIndex offset
`timescale 1ns/1ns
`default_nettype none
module uvrd_decoder
(
  input  wire logic        core_clk_in,
  input  wire logic        reset_n_in,
  // setup packet from the device core
  input  wire logic        setup_valid_in,
  input  wire logic [3:0]  setup_ep_in,
  input  wire logic [7:0]  setup_type_in,
  input  wire logic [7:0]  setup_request_in,
  input  wire logic [15:0] setup_value_in,
  input  wire logic [15:0] setup_index_in,
  input  wire logic [15:0] setup_length_in,
  // command table lookup
  output logic [7:0]       lookup_cmd_out,
  input  wire logic [2:0]  lookup_fmt_in,
  // decoded command
  output logic             cmd_valid_out,
  output logic [2:0]       cmd_fmt_out,
  output logic [7:0]       cmd_byte_out,
  output logic [31:0]      cmd_value_out,
  output logic [15:0]      cmd_offset_out,
  output logic             stall_out,
  output logic [2:0]       reject_reason_out,
  output logic             busy_out,
  // response data block
  output logic [15:0]      blk_addr_out,
  input  wire logic [7:0]  blk_data_in,
  // data-in stage
  output logic [7:0]       in_data_out,
  output logic             in_valid_out,
  output logic             in_last_out,
  input  wire logic        in_ready_in
);

  uvrd_pkg::uvrd_dec_t d_r;
  uvrd_pkg::uvrd_dec_t d_nxt;

  uvrd_rsp_if rsp ();

  uvrd_pkg::uvrd_fmt_t fmt;
  logic                type_write;
  logic                type_read;
  logic                ep_ok;
  logic                value_zero;
  logic                index_zero;
  logic                length_zero;
  logic                value_hi_zero;
  logic                len_in_range;
  logic                fields_ok;
  logic                accept;
  uvrd_pkg::uvrd_rej_t reason;
  logic [31:0]         value;
  logic [15:0]         offset;

  // table answers combinationally for the current request byte
  assign lookup_cmd_out = setup_request_in;
  assign fmt            = uvrd_pkg::uvrd_fmt_t'(lookup_fmt_in);

  assign ep_ok         = (setup_ep_in == uvrd_pkg::CTRL_EP);
  assign type_write    = (setup_type_in == uvrd_pkg::REQ_TYPE_WRITE);
  assign type_read     = (setup_type_in == uvrd_pkg::REQ_TYPE_READ);
  assign value_zero    = (setup_value_in == 16'h0000);
  assign index_zero    = (setup_index_in == 16'h0000);
  assign length_zero   = (setup_length_in == 16'h0000);
  assign value_hi_zero = (setup_value_in[15:8] == 8'h00);
  assign len_in_range  = (setup_length_in >= uvrd_pkg::READ_LEN_MIN) &&
                         (setup_length_in <= uvrd_pkg::READ_LEN_MAX);

  // field checks and value assembly per layout
  always_comb
  begin
    fields_ok = 1'b0;
    value     = 32'h0000_0000;
    offset    = 16'h0000;
    unique case (fmt)
      uvrd_pkg::UVRD_FMT_QUICK:
      begin
        fields_ok = type_write && value_zero && index_zero &&
                    length_zero;
      end
      uvrd_pkg::UVRD_FMT_WRITE7:
      begin
        fields_ok = type_write && value_hi_zero &&
                    !setup_value_in[7] && index_zero &&
                    length_zero;
        value     = {25'h0, setup_value_in[6:0]};
      end
      uvrd_pkg::UVRD_FMT_WRITE32:
      begin
        fields_ok = type_write && length_zero;
        value     = {setup_index_in, setup_value_in};
      end
      uvrd_pkg::UVRD_FMT_READ:
      begin
        fields_ok = type_read && value_zero;
        offset    = setup_index_in;
      end
      uvrd_pkg::UVRD_FMT_SETTING:
      begin
        fields_ok = type_write && value_hi_zero && length_zero;
        value     = {24'h0, setup_value_in[7:0]};
        offset    = setup_index_in;
      end
      default:
      begin
        fields_ok = 1'b0;
      end
    endcase
  end

  // first failing check names the reject reason
  always_comb
  begin
    reason = uvrd_pkg::UVRD_REJ_NONE;
    if (!ep_ok)
      reason = uvrd_pkg::UVRD_REJ_ENDPOINT;
    else if (!type_write && !type_read)
      reason = uvrd_pkg::UVRD_REJ_TYPE;
    else if (fmt == uvrd_pkg::UVRD_FMT_NONE)
      reason = uvrd_pkg::UVRD_REJ_UNKNOWN;
    else if (!fields_ok)
      reason = uvrd_pkg::UVRD_REJ_FIELDS;
    else if (fmt == uvrd_pkg::UVRD_FMT_READ && !len_in_range)
      reason = uvrd_pkg::UVRD_REJ_LENGTH;
    else if (d_r.st != uvrd_pkg::UVRD_DEC_IDLE)
      reason = uvrd_pkg::UVRD_REJ_BUSY;
  end

  assign accept = (reason == uvrd_pkg::UVRD_REJ_NONE);

  always_comb
  begin
    d_nxt           = d_r;
    d_nxt.cmd_valid = 1'b0;
    d_nxt.stall     = 1'b0;
    d_nxt.start     = 1'b0;
    unique case (d_r.st)
      uvrd_pkg::UVRD_DEC_IDLE:
      begin
        if (setup_valid_in && accept)
        begin
          d_nxt.cmd_valid = 1'b1;
          d_nxt.fmt       = fmt;
          d_nxt.cmd       = setup_request_in;
          d_nxt.value     = value;
          d_nxt.offset    = offset;
          d_nxt.reason    = uvrd_pkg::UVRD_REJ_NONE;
          if (fmt == uvrd_pkg::UVRD_FMT_READ)
          begin
            d_nxt.start  = 1'b1;
            d_nxt.rd_len = setup_length_in[7:0];
            d_nxt.st     = uvrd_pkg::UVRD_DEC_READ;
          end
        end
        else if (setup_valid_in)
        begin
          // command outputs hold the last good request
          d_nxt.stall  = 1'b1;
          d_nxt.reason = reason;
        end
      end
      uvrd_pkg::UVRD_DEC_READ:
      begin
        // a new setup mid-answer is refused, not spliced in
        if (setup_valid_in)
        begin
          d_nxt.stall  = 1'b1;
          d_nxt.reason = reason;
        end
        if (rsp.done)
          d_nxt.st = uvrd_pkg::UVRD_DEC_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk_in)
  begin
    if (!reset_n_in)
      d_r <= uvrd_pkg::DEC_RESET;
    else
      d_r <= d_nxt;
  end

  assign rsp.start  = d_r.start;
  assign rsp.offset = d_r.offset;
  assign rsp.length = d_r.rd_len;

  uvrd_rsp_serializer u_ser
  (
    .core_clk_in  (core_clk_in),
    .reset_n_in   (reset_n_in),
    .rsp          (rsp),
    .blk_addr_out (blk_addr_out),
    .blk_data_in  (blk_data_in),
    .in_data_out  (in_data_out),
    .in_valid_out (in_valid_out),
    .in_last_out  (in_last_out),
    .in_ready_in  (in_ready_in)
  );

  assign cmd_valid_out     = d_r.cmd_valid;
  assign cmd_fmt_out       = d_r.fmt;
  assign cmd_byte_out      = d_r.cmd;
  assign cmd_value_out     = d_r.value;
  assign cmd_offset_out    = d_r.offset;
  assign stall_out         = d_r.stall;
  assign reject_reason_out = d_r.reason;
  // serializer state kept in view so a stuck beat still shows busy
  assign busy_out          = (d_r.st != uvrd_pkg::UVRD_DEC_IDLE) ||
                             rsp.busy;

endmodule // uvrd_decoder
`default_nettype wire

// ===== rtl/uvrd_pkg.sv
// uvrd_pkg: constants and types for the vendor request decoder
// assumes the device core delivers decoded SETUP fields on core_clk_in
package uvrd_pkg;

  // request type bytes and control endpoint
  localparam logic [7:0]  REQ_TYPE_WRITE = 8'h40;
  localparam logic [7:0]  REQ_TYPE_READ  = 8'hC0;
  localparam logic [3:0]  CTRL_EP        = 4'h0;

  // block read length window
  localparam logic [15:0] READ_LEN_MIN   = 16'h0001;
  localparam logic [15:0] READ_LEN_MAX   = 16'h0080;

  // command layouts as reported by the command table
  typedef enum logic [2:0] {
    UVRD_FMT_NONE    = 3'h0,
    UVRD_FMT_QUICK   = 3'h1,
    UVRD_FMT_WRITE7  = 3'h2,
    UVRD_FMT_WRITE32 = 3'h3,
    UVRD_FMT_READ    = 3'h4,
    UVRD_FMT_SETTING = 3'h5
  } uvrd_fmt_t;

  // why the last request was stalled
  typedef enum logic [2:0] {
    UVRD_REJ_NONE     = 3'h0,
    UVRD_REJ_ENDPOINT = 3'h1,
    UVRD_REJ_TYPE     = 3'h2,
    UVRD_REJ_UNKNOWN  = 3'h3,
    UVRD_REJ_FIELDS   = 3'h4,
    UVRD_REJ_LENGTH   = 3'h5,
    UVRD_REJ_BUSY     = 3'h6
  } uvrd_rej_t;

  typedef enum logic [1:0] {
    UVRD_DEC_IDLE = 2'b01,
    UVRD_DEC_READ = 2'b10
  } uvrd_dec_state_t;

  typedef enum logic [2:0] {
    UVRD_SER_IDLE = 3'b001,
    UVRD_SER_LOAD = 3'b010,
    UVRD_SER_SEND = 3'b100
  } uvrd_ser_state_t;

  typedef struct packed {
    uvrd_dec_state_t st;
    logic            cmd_valid;
    logic            stall;
    uvrd_fmt_t       fmt;
    logic [7:0]      cmd;
    logic [31:0]     value;
    logic [15:0]     offset;
    uvrd_rej_t       reason;
    logic            start;
    logic [7:0]      rd_len;
  } uvrd_dec_t;

  typedef struct packed {
    uvrd_ser_state_t st;
    logic [15:0]     addr;
    logic [7:0]      remain;
    logic [7:0]      data;
    logic            last;
  } uvrd_ser_t;

  localparam uvrd_dec_t DEC_RESET = '{
    st:        UVRD_DEC_IDLE,
    cmd_valid: 1'b0,
    stall:     1'b0,
    fmt:       UVRD_FMT_NONE,
    cmd:       8'h00,
    value:     32'h0000_0000,
    offset:    16'h0000,
    reason:    UVRD_REJ_NONE,
    start:     1'b0,
    rd_len:    8'h00
  };

  localparam uvrd_ser_t SER_RESET = '{
    st:     UVRD_SER_IDLE,
    addr:   16'h0000,
    remain: 8'h00,
    data:   8'h00,
    last:   1'b0
  };

endpackage

// ===== rtl/uvrd_rsp_if.sv
// uvrd_rsp_if: decoder to response serializer hand-off
// assumes both ends run on the same clock
`timescale 1ns/1ns
`default_nettype none
interface uvrd_rsp_if;
  logic        start;
  logic [15:0] offset;
  logic [7:0]  length;
  logic        busy;
  logic        done;

  modport ctrl (output start, output offset, output length,
                input busy, input done);
  modport ser  (input start, input offset, input length,
                output busy, output done);
endinterface
`default_nettype wire

// ===== rtl/uvrd_rsp_serializer.sv
// uvrd_rsp_serializer: streams a block read answer, one byte per beat
// assumes blk_data_in answers blk_addr_out in the same cycle
`timescale 1ns/1ns
`default_nettype none
module uvrd_rsp_serializer
(
  input  wire logic   core_clk_in,
  input  wire logic   reset_n_in,
  uvrd_rsp_if.ser     rsp,
  output logic [15:0] blk_addr_out,
  input  wire logic [7:0] blk_data_in,
  output logic [7:0]  in_data_out,
  output logic        in_valid_out,
  output logic        in_last_out,
  input  wire logic   in_ready_in
);

  uvrd_pkg::uvrd_ser_t s_r;
  uvrd_pkg::uvrd_ser_t s_nxt;

  always_comb
  begin
    s_nxt = s_r;
    unique case (s_r.st)
      uvrd_pkg::UVRD_SER_IDLE:
      begin
        if (rsp.start)
        begin
          s_nxt.addr   = rsp.offset;
          s_nxt.remain = rsp.length;
          s_nxt.st     = uvrd_pkg::UVRD_SER_LOAD;
        end
      end
      uvrd_pkg::UVRD_SER_LOAD:
      begin
        s_nxt.data = blk_data_in;
        s_nxt.last = (s_r.remain == 8'h01);
        s_nxt.st   = uvrd_pkg::UVRD_SER_SEND;
      end
      uvrd_pkg::UVRD_SER_SEND:
      begin
        if (in_ready_in)
        begin
          // ascending addresses give low byte first
          s_nxt.addr   = 16'(s_r.addr + 16'h0001);
          s_nxt.remain = 8'(s_r.remain - 8'h01);
          s_nxt.st     = s_r.last ? uvrd_pkg::UVRD_SER_IDLE
                                  : uvrd_pkg::UVRD_SER_LOAD;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk_in)
  begin
    if (!reset_n_in)
      s_r <= uvrd_pkg::SER_RESET;
    else
      s_r <= s_nxt;
  end

  assign rsp.busy     = (s_r.st != uvrd_pkg::UVRD_SER_IDLE);
  assign rsp.done     = (s_r.st == uvrd_pkg::UVRD_SER_SEND) &&
                        in_ready_in && s_r.last;
  assign blk_addr_out = s_r.addr;
  assign in_data_out  = s_r.data;
  assign in_valid_out = (s_r.st == uvrd_pkg::UVRD_SER_SEND);
  assign in_last_out  = s_r.last;

endmodule // uvrd_rsp_serializer
`default_nettype wire

// ===== tb/uvrd_decoder_chk.sv
// uvrd_decoder_chk: port-level assertions for the request decoder
// assumes only the decoder's top ports, bound after the module
`timescale 1ns/1ns
`default_nettype none
module uvrd_decoder_chk
(
  input wire logic        core_clk_in,
  input wire logic        reset_n_in,
  input wire logic        setup_valid_in,
  input wire logic [3:0]  setup_ep_in,
  input wire logic [7:0]  setup_type_in,
  input wire logic [15:0] setup_value_in,
  input wire logic [15:0] setup_index_in,
  input wire logic [15:0] setup_length_in,
  input wire logic [2:0]  lookup_fmt_in,
  input wire logic        cmd_valid_out,
  input wire logic [2:0]  cmd_fmt_out,
  input wire logic [31:0] cmd_value_out,
  input wire logic [15:0] cmd_offset_out,
  input wire logic        stall_out,
  input wire logic [2:0]  reject_reason_out,
  input wire logic        busy_out,
  input wire logic [15:0] blk_addr_out,
  input wire logic [7:0]  in_data_out,
  input wire logic        in_valid_out,
  input wire logic        in_ready_in
);
  default clocking dc @(posedge core_clk_in);
  endclocking
  default disable iff (!reset_n_in);
  // idle setup on endpoint 0; busy stalls outrank nothing else
  wire logic ok_w = setup_valid_in && setup_ep_in == 4'h0 && !busy_out;
  wire logic rd_w = setup_valid_in && setup_ep_in == 4'h0
    && setup_type_in == 8'hC0 && lookup_fmt_in == 3'h4;

  one_answer_a: assert property (setup_valid_in |=> cmd_valid_out != stall_out)
    else $error("setup not answered exactly once");
  no_stray_a: assert property (!setup_valid_in |=> !cmd_valid_out && !stall_out)
    else $error("decision without a setup");
  ep_stall_a: assert property (setup_valid_in && setup_ep_in != 4'h0
    |=> stall_out && reject_reason_out == 3'h1) else $error("endpoint not refused");
  quick_zero_a: assert property (ok_w && setup_type_in == 8'h40
    && lookup_fmt_in == 3'h1 && {setup_value_in, setup_index_in,
    setup_length_in} == 48'h0 |=> cmd_valid_out && cmd_value_out == 32'h0)
    else $error("quick request not accepted");
  pair_w32_a: assert property (ok_w && setup_type_in == 8'h40
    && lookup_fmt_in == 3'h3 && setup_length_in == 16'h0 |=> cmd_valid_out
    && cmd_value_out == {$past(setup_index_in), $past(setup_value_in)})
    else $error("wide value halves wrong");
  len_stall_a: assert property (rd_w && setup_value_in == 16'h0
    && (setup_length_in == 16'h0 || setup_length_in > 16'h0080)
    |=> stall_out && reject_reason_out == 3'h5) else $error("bad length taken");
  rd_start_a: assert property (cmd_valid_out && cmd_fmt_out == 3'h4
    |=> blk_addr_out == cmd_offset_out) else $error("read not at offset");
  in_hold_a: assert property (in_valid_out && !in_ready_in
    |=> in_valid_out && $stable(in_data_out)) else $error("byte dropped");
  busy_stall_a: assert property (busy_out && setup_valid_in |=> stall_out)
    else $error("setup taken during read");

  cover property (in_valid_out && !in_ready_in);
  cover property (stall_out && reject_reason_out == 3'h6);
  cover property (cmd_valid_out && cmd_fmt_out == 3'h3);
endmodule // uvrd_decoder_chk

bind uvrd_decoder uvrd_decoder_chk u_uvrd_decoder_chk (.*);
`default_nettype wire

// ===== tb/uvrd_host_model.sv
// uvrd_host_model: host side, issues setups and takes data-in bytes
// assumes the bench calls send between setups, never overlapping
`timescale 1ns/1ns
`default_nettype none
module uvrd_host_model
(
  input  wire logic   core_clk_in,
  input  wire logic   slow_in,
  output logic        setup_valid_in,
  output logic [3:0]  setup_ep_in,
  output logic [7:0]  setup_type_in,
  output logic [7:0]  setup_request_in,
  output logic [15:0] setup_value_in,
  output logic [15:0] setup_index_in,
  output logic [15:0] setup_length_in,
  output logic        in_ready_in
);
  logic [1:0] tog_r = 2'h0;
  always @(posedge core_clk_in) tog_r <= tog_r + 2'h1;
  // slow host takes one byte in four cycles
  assign in_ready_in = !slow_in || tog_r == 2'h3;
  initial
  begin
    setup_valid_in = 1'b0;
    {setup_ep_in, setup_type_in, setup_request_in} = 20'h0;
    {setup_value_in, setup_index_in, setup_length_in} = 48'h0;
  end
  // value, index and length are not held after the strobe: show inverted junk
  task automatic send(input logic [3:0] ep, input logic [7:0] ty,
    input logic [7:0] rq, input logic [15:0] v, input logic [15:0] i,
    input logic [15:0] l);
    @(posedge core_clk_in);
    #1;
    setup_valid_in = 1'b1;
    {setup_ep_in, setup_type_in, setup_request_in} = {ep, ty, rq};
    {setup_value_in, setup_index_in, setup_length_in} = {v, i, l};
    @(posedge core_clk_in);
    #1;
    setup_valid_in = 1'b0;
    {setup_value_in, setup_index_in} = ~{setup_value_in, setup_index_in};
    setup_length_in = ~setup_length_in;
  endtask
endmodule // uvrd_host_model
`default_nettype wire

// ===== tb/tb_uvrd_decoder.sv
// tb_uvrd_decoder: self-checking bench for the vendor request decoder
// assumes uvrd_host_model as the host and a stand-in table and data block
`timescale 1ns/1ns
`default_nettype none
module tb_uvrd_decoder;
  logic core_clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic slow_r = 1'b0;
  logic setup_valid_in, stall_out, busy_out, cmd_valid_out;
  logic in_valid_out, in_last_out, in_ready_in;
  logic [3:0] setup_ep_in;
  logic [7:0] setup_type_in, setup_request_in, lookup_cmd_out;
  logic [7:0] cmd_byte_out, blk_data_in, in_data_out;
  logic [15:0] setup_value_in, setup_index_in, setup_length_in;
  logic [15:0] cmd_offset_out, blk_addr_out;
  logic [2:0] lookup_fmt_in, cmd_fmt_out, reject_reason_out;
  logic [31:0] cmd_value_out;
  int err_count = 0;
  int n_tests = 0;

  always #5 core_clk_in = ~core_clk_in;
  // stand-in table: command bytes 1..5 give the five layouts
  assign lookup_fmt_in = (lookup_cmd_out >= 8'h01 && lookup_cmd_out <= 8'h05)
    ? lookup_cmd_out[2:0] : 3'h0;
  // byte tied to its address so order and offset show
  assign blk_data_in = blk_addr_out[7:0] ^ 8'h5A;

  uvrd_decoder u_uvrd_decoder (.*);
  uvrd_host_model u_uvrd_host_model (.*, .slow_in(slow_r));

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen,
    input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      err_count++;
      $display("FAIL %s exp %h seen %h", what, exp, seen);
    end
  endtask

  // one setup; why is the expected refusal code, 0 for accept
  task automatic req(input logic [3:0] ep, input logic [7:0] ty,
    input logic [7:0] rq, input logic [15:0] v, input logic [15:0] i,
    input logic [15:0] l, input logic [2:0] why);
    u_uvrd_host_model.send(ep, ty, rq, v, i, l);
    chk("stall", {31'h0, stall_out}, {31'h0, why != 3'h0});
    chk("accept", {31'h0, cmd_valid_out}, {31'h0, why == 3'h0});
    chk("reason", {29'h0, reject_reason_out}, {29'h0, why});
    if (why == 3'h0)
    begin
      chk("cmd", {24'h0, cmd_byte_out}, {24'h0, rq});
      chk("fmt", {29'h0, cmd_fmt_out}, {29'h0, rq[2:0]});
    end
  endtask

  task automatic t_writes();
    req(4'h0, 8'h40, 8'h01, 16'h0, 16'h0, 16'h0, 3'h0);
    chk("quick", cmd_value_out, 32'h0);
    req(4'h0, 8'h40, 8'h02, 16'h007F, 16'h0, 16'h0, 3'h0);
    chk("w7", cmd_value_out, 32'h7F);
    req(4'h0, 8'h40, 8'h02, 16'h0080, 16'h0, 16'h0, 3'h4);
    chk("kept", cmd_value_out, 32'h7F);
    req(4'h0, 8'h40, 8'h03, 16'h02D2, 16'h4996, 16'h0, 3'h0);
    chk("w32", cmd_value_out, 32'h499602D2);
    chk("w32off", {16'h0, cmd_offset_out}, 32'h0);
    req(4'h0, 8'h40, 8'h03, 16'h1234, 16'h5678, 16'h4, 3'h4);
    req(4'h0, 8'h40, 8'h01, 16'h0, 16'h0001, 16'h0, 3'h4);
    req(4'h0, 8'hC0, 8'h01, 16'h0, 16'h0, 16'h0, 3'h4);
    req(4'h0, 8'h40, 8'h02, 16'h0005, 16'h0, 16'h0001, 3'h4);
    req(4'h0, 8'h40, 8'h04, 16'h0, 16'h0, 16'h4, 3'h4);
    req(4'h0, 8'h40, 8'h05, 16'h00FF, 16'h0041, 16'h0, 3'h0);
    chk("set", cmd_value_out, 32'hFF);
    chk("setoff", {16'h0, cmd_offset_out}, 32'h41);
    req(4'h0, 8'h40, 8'h05, 16'h0103, 16'h0041, 16'h0, 3'h4);
    req(4'h0, 8'h40, 8'h05, 16'h0003, 16'h0041, 16'h1, 3'h4);
    chk("setkept", cmd_value_out, 32'hFF);
    req(4'h1, 8'h40, 8'h01, 16'h0, 16'h0, 16'h0, 3'h1);
    req(4'h0, 8'h41, 8'h01, 16'h0, 16'h0, 16'h0, 3'h2);
    req(4'h0, 8'h40, 8'h77, 16'h0, 16'h0, 16'h0, 3'h3);
    req(4'h0, 8'hC0, 8'h04, 16'h0, 16'h0, 16'h0, 3'h5);
    req(4'h0, 8'hC0, 8'h04, 16'h0, 16'h0, 16'h0081, 3'h5);
    req(4'h0, 8'hC0, 8'h04, 16'h0001, 16'h0, 16'h4, 3'h4);
  endtask

  // read while a second setup is poked in and must stall
  task automatic t_read(input logic [15:0] off, input logic [7:0] len,
    input logic slow);
    int k;
    k = 0;
    slow_r = slow;
    req(4'h0, 8'hC0, 8'h04, 16'h0, off, {8'h0, len}, 3'h0);
    chk("offset", {16'h0, cmd_offset_out}, {16'h0, off});
    fork
      for (int c = 0; c < 3000 && k < len; c++)
      begin
        @(posedge core_clk_in);
        if (in_valid_out === 1'b1 && in_ready_in === 1'b1)
        begin
          chk("data", {24'h0, in_data_out}, {24'h0, 8'(off + k) ^ 8'h5A});
          chk("last", {31'h0, in_last_out}, {31'h0, k == len - 1});
          k++;
        end
      end
      req(4'h0, 8'h40, 8'h01, 16'h0, 16'h0, 16'h0, 3'h6);
    join
    chk("bytes", k, {24'h0, len});
    if (k != len)
      tally_and_finish();
    repeat (3) @(posedge core_clk_in);
    #1;
    chk("done", {30'h0, busy_out, in_valid_out}, 32'h0);
  endtask

  initial
  begin
    repeat (3) @(posedge core_clk_in);
    #1;
    reset_n_in = 1'b1;
    t_writes();
    t_read(16'h000A, 8'h04, 1'b0);
    t_read(16'hFFC0, 8'h80, 1'b1);
    t_read(16'h0003, 8'h01, 1'b1);
    tally_and_finish();
  end
endmodule // tb_uvrd_decoder
`default_nettype wire
